// ===== verilog/sld_ctrl.sv
/*
 supply level detector control: ahb-lite register slave, settling
 count on the 8 kHz tick, comparator synchroniser and agreement filter.
 assumes the 8 kHz clock is synchronous to core_clk, the comparator
 output is asynchronous, and cold_rst is raised with rst at power-up.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`include "sld_cfg.svh"
module sld_ctrl
	import sld_pkg::*;
#(
	parameter int EOM_CYCLES = `SLD_EOM_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cold_rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic slow_8khz_clock,
	input wire logic comp_below,
	output logic analog_power_en,
	output logic range_double_select,
	output logic [2:0] threshold_tune,
	output logic supply_low_irq
);

	// map a byte address onto a register
	function automatic sld_sel_e decode(input logic [31:0] a);
		if (a[31:8] != 24'h00_0000)
			return SLD_SEL_NONE;
		case (a[7:0])
			`SLD_OFF_CTRL: return SLD_SEL_CTRL;
			`SLD_OFF_STAT: return SLD_SEL_STAT;
			`SLD_OFF_MASK: return SLD_SEL_MASK;
			default: return SLD_SEL_NONE;
		endcase
	endfunction

	// three samples alike; bit1 = agree, bit0 = value
	function automatic logic [1:0] agree3(input logic [2:0] h);
		return {(h == 3'b111) || (h == 3'b000), h[0]};
	endfunction

	sld_aphase_s ap; // pending data phase
	sld_aphase_s next_ap;
	logic [31:0] next_hrdata;
	sld_ctrl_s ctrl; // range and tune
	sld_ctrl_s next_ctrl;
	logic irq_mask; // software gate on the request
	logic next_irq_mask;
	logic next_en;
	sld_state_e st; // measurement state
	sld_state_e next_st;
	logic [4:0] edge_cnt; // 8 kHz edges since enable, held at 16 once valid
	logic [4:0] next_edge_cnt;
	logic [2:0] samp_hist; // last three comparator samples
	logic [2:0] next_samp_hist;
	logic valid; // result valid
	logic next_valid;
	logic low; // filtered low supply
	logic next_low;
	logic next_irq;
	logic slow_clk_q; // last 8 kHz level, for edge detection
	logic cmp_s1; // synchroniser, first stage
	logic cmp_s2; // synchroniser, second stage
	logic tick; // rising 8 kHz edge
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic [1:0] agree;
	logic [31:0] eom_cnt; // cycles spent settling
	logic [31:0] next_eom_cnt;

	// writes land in the data phase, zero wait states
	assign wr_ctrl = ce && ap.valid && ap.write && ap.sel == SLD_SEL_CTRL;
	assign wr_stat = ce && ap.valid && ap.write && ap.sel == SLD_SEL_STAT;
	assign wr_mask = ce && ap.valid && ap.write && ap.sel == SLD_SEL_MASK;
	assign tick = slow_8khz_clock && !slow_clk_q;

	// bus next values; read data built from next register values
	// so a write just before a read is seen
	always_comb begin
		next_ap = ap;
		next_hrdata = hrdata;
		if (ce && hready) begin
			next_ap.valid = hsel && htrans[1];
			next_ap.write = hwrite;
			next_ap.sel = decode(haddr);
			next_hrdata = 32'h0000_0000;
			if (hsel && htrans[1] && !hwrite) begin
				case (decode(haddr))
					SLD_SEL_CTRL: begin
						next_hrdata[`SLD_RANGE_BIT] = next_ctrl.range;
						next_hrdata[`SLD_TUNE_LSB +: `SLD_TUNE_W] = next_ctrl.tune;
					end
					SLD_SEL_STAT: begin
						next_hrdata[`SLD_EN_BIT] = next_en;
						next_hrdata[`SLD_VALID_BIT] = next_valid;
						next_hrdata[`SLD_LOW_BIT] = next_low;
					end
					SLD_SEL_MASK: next_hrdata[`SLD_MASK_BIT] = next_irq_mask;
					default: next_hrdata = 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end

	// bus registers; always ready, always okay
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ap <= '{valid: 1'b0, write: 1'b0, sel: SLD_SEL_NONE};
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ap <= next_ap;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// control next values
	always_comb begin
		next_ctrl = ctrl;
		if (wr_ctrl) begin
			next_ctrl.range = hwdata[`SLD_RANGE_BIT];
			next_ctrl.tune = hwdata[`SLD_TUNE_LSB +: `SLD_TUNE_W];
		end
	end

	always_ff @(posedge core_clk or posedge cold_rst) begin
		if (cold_rst) begin
			ctrl <= `SLD_CTRL_RST;
			range_double_select <= 1'b0;
			threshold_tune <= 3'h0;
		end else begin
			ctrl <= next_ctrl;
			range_double_select <= next_ctrl.range;
			threshold_tune <= next_ctrl.tune;
		end
	end

	// measurement next values
	always_comb begin
		next_en = analog_power_en;
		next_irq_mask = irq_mask;
		next_st = st;
		next_edge_cnt = edge_cnt;
		next_samp_hist = samp_hist;
		next_valid = valid;
		next_low = low;
		agree = agree3({samp_hist[1:0], cmp_s2});
		if (wr_stat)
			next_en = hwdata[`SLD_EN_BIT];
		if (wr_mask)
			next_irq_mask = hwdata[`SLD_MASK_BIT];
		if (ce) begin
			case (st)
				SLD_OFF: begin
					if (analog_power_en) begin
						next_st = SLD_SETTLE;
						next_edge_cnt = 5'd0;
						next_samp_hist = 3'b000;
					end
				end
				SLD_SETTLE, SLD_RUN: begin
					if (!analog_power_en) begin
						next_st = SLD_OFF;
						next_edge_cnt = 5'd0;
						next_samp_hist = 3'b000;
						next_valid = 1'b0;
						next_low = 1'b0;
					end else if (tick) begin
						next_samp_hist = {samp_hist[1:0], cmp_s2};
						if (agree[1])
							next_low = agree[0];
						if (st == SLD_SETTLE) begin
							next_edge_cnt = edge_cnt + 5'd1;
							if (edge_cnt == 5'(`SLD_SETTLE_EDGES - 1)) begin
								next_valid = 1'b1;
								next_st = SLD_RUN;
							end
						end
					end
				end
				default: next_st = SLD_OFF;
			endcase
		end
		next_irq = next_valid && next_low && next_irq_mask;
	end

	// measurement registers, system reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			analog_power_en <= 1'b0;
			irq_mask <= `SLD_MASK_RST;
			st <= SLD_OFF;
			edge_cnt <= 5'd0;
			samp_hist <= 3'b000;
			valid <= 1'b0;
			low <= 1'b0;
			supply_low_irq <= 1'b0;
		end else begin
			analog_power_en <= next_en;
			irq_mask <= next_irq_mask;
			st <= next_st;
			edge_cnt <= next_edge_cnt;
			samp_hist <= next_samp_hist;
			valid <= next_valid;
			low <= next_low;
			supply_low_irq <= next_irq;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			slow_clk_q <= 1'b0;
		end else if (ce) begin
			cmp_s1 <= comp_below;
			cmp_s2 <= cmp_s1;
			slow_clk_q <= slow_8khz_clock;
		end
	end

	// settling-time helper, only read by the 2 ms check; saturates rather
	// than wraps, and stalls with ce so a frozen block is not blamed
	always_comb begin
		next_eom_cnt = eom_cnt;
		if (st != SLD_SETTLE)
			next_eom_cnt = 32'h0000_0000;
		else if (ce && eom_cnt != 32'hFFFF_FFFF)
			next_eom_cnt = eom_cnt + 32'h0000_0001;
	end

	// settling-time helper register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			eom_cnt <= 32'h0000_0000;
		else
			eom_cnt <= next_eom_cnt;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || cold_rst);

	// disable request while measuring, and the cleared state after it
	sequence off_req_s;
		ce && !analog_power_en && st != SLD_OFF;
	endsequence
	sequence cleared_s;
		!valid && !low && edge_cnt == 5'd0 && samp_hist == 3'b000;
	endsequence
	// enable seen while idle, and the fresh settling state after it
	sequence start_req_s;
		ce && analog_power_en && st == SLD_OFF;
	endsequence
	sequence fresh_s;
		st == SLD_SETTLE && edge_cnt == 5'd0 && !valid;
	endsequence
	sequence settle_last_s;
		ce && tick && analog_power_en && st == SLD_SETTLE && edge_cnt == 5'd15;
	endsequence
	sequence run_entered_s;
		valid && st == SLD_RUN;
	endsequence
	// a sampling tick while the result is already valid
	sequence run_tick_s;
		ce && tick && st == SLD_RUN && analog_power_en;
	endsequence
	sequence stat_write_s;
		wr_stat;
	endsequence

	off_clears_a: assert property (off_req_s |=> cleared_s)
		else $error("disable did not clear");
	start_meas_a: assert property (start_req_s |=> fresh_s)
		else $error("measurement not started");
	valid_16th_a: assert property (settle_last_s |=> run_entered_s)
		else $error("valid not on edge 16");
	// enable is taken one cycle back: a disable may land on the same edge
	valid_count_a: assert property ($rose(valid) |->
		edge_cnt == 5'd16 && $past(analog_power_en))
		else $error("valid at wrong count");
	eom_bound_a: assert property (eom_cnt <= EOM_CYCLES)
		else $error("measurement over 2 ms");
	low_rise_a: assert property ($rose(low) |->
		samp_hist == 3'b111 && $past(analog_power_en))
		else $error("low set without agreement");
	low_fall_a: assert property ($fell(low) |-> samp_hist == 3'b000)
		else $error("low cleared without agreement");
	irq_level_a: assert property (supply_low_irq == (valid && low && irq_mask))
		else $error("irq differs from result");
	run_sample_a: assert property (run_tick_s |=>
		st == SLD_RUN && samp_hist == {$past(samp_hist[1:0]), $past(cmp_s2)})
		else $error("run stopped sampling");
	one_sample_a: assert property (!(ce && tick) && st != SLD_OFF |=>
		$stable(samp_hist) || st == SLD_OFF)
		else $error("sample between ticks");
	tune_write_a: assert property (wr_ctrl |=>
		threshold_tune == $past(hwdata[2:0]) && range_double_select == $past(hwdata[3]))
		else $error("control write lost");
	en_write_a: assert property (stat_write_s |=>
		analog_power_en == $past(hwdata[`SLD_EN_BIT]))
		else $error("enable write lost");
	ctrl_hold_a: assert property (!wr_ctrl |=>
		$stable(range_double_select) && $stable(threshold_tune))
		else $error("control changed without write");

endmodule

// ===== verilog/sld_cfg.svh
/*
 offsets, field positions, reset values and timing counts of the
 supply level detector; assumes a 100 MHz core clock.
*/
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH
// byte offsets on the bus
`define SLD_OFF_CTRL 8'h00
`define SLD_OFF_STAT 8'h04
`define SLD_OFF_MASK 8'h08
// control fields
`define SLD_TUNE_LSB 0
`define SLD_TUNE_W 3
`define SLD_RANGE_BIT 3
// status fields
`define SLD_EN_BIT 0
`define SLD_VALID_BIT 1
`define SLD_LOW_BIT 2
// interrupt mask field
`define SLD_MASK_BIT 0
// reset values
`define SLD_CTRL_RST 4'h0
`define SLD_MASK_RST 1'b0
// timing
`define SLD_SETTLE_EDGES 16
`define SLD_TEOM_MS 2
`define SLD_CLK_MHZ 100
`define SLD_EOM_CYCLES (`SLD_TEOM_MS * 1000 * 1000 * `SLD_CLK_MHZ / 1000)
`endif

// ===== verilog/sld_pkg.sv
/*
 types of the supply level detector: states and carriers.
 assumes sld_cfg.svh is included by the user of the package.
*/
package sld_pkg;
	// measurement states, one-hot
	typedef enum logic [2:0] {
		SLD_OFF = 3'b001,
		SLD_SETTLE = 3'b010,
		SLD_RUN = 3'b100
	} sld_state_e;
	// register selector of a bus access
	typedef enum logic [1:0] {
		SLD_SEL_CTRL = 2'b00,
		SLD_SEL_STAT = 2'b01,
		SLD_SEL_MASK = 2'b10,
		SLD_SEL_NONE = 2'b11
	} sld_sel_e;
	// captured address phase
	typedef struct packed {
		logic valid;
		logic write;
		sld_sel_e sel;
	} sld_aphase_s;
	// cold-reset control fields
	typedef struct packed {
		logic range;
		logic [2:0] tune;
	} sld_ctrl_s;
endpackage

// ===== tb/sld_supply_model.sv
/*
 far side of sld_ctrl: supply comparator and the slow tick source.
 assumes the bench sets supply_mv; the tick period is shortened to TICK core cycles.
*/
module sld_supply_model #(
	parameter int TICK = 20
) (
	input wire logic core_clk,
	input wire logic analog_power_en,
	input wire logic range_double_select,
	input wire logic [2:0] threshold_tune,
	input wire logic [15:0] supply_mv,
	output logic slow_8khz_clock,
	output logic comp_below
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0; // phase within one tick period
	int thr; // threshold in millivolts
	logic slow_q = 1'b0; // tick level driven out
	logic comp_q = 1'b0; // comparator level driven out
	assign slow_8khz_clock = slow_q;
	assign comp_below = comp_q;
	// free running tick, high for half a period
	always @(posedge core_clk) begin
		cnt <= (cnt + 1) % TICK;
		slow_q <= (cnt < TICK / 2);
	end
	always_comb begin
		thr = range_double_select ? 2550 : 1300;
		thr = thr * (100 + 6 * (int'(threshold_tune) - 4)) / 100;
	end
	always @(posedge core_clk) begin
		comp_q <= analog_power_en ? (supply_mv < thr) : ~comp_q;
	end
endmodule

// ===== tb/tb_top.sv
/*
 self-checking bench of sld_ctrl with a polling model of the detector.
 assumes sld_cfg.svh on the include path and a free running tick.
*/
`include "sld_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 20; // short tick keeps the run brief
	logic core_clk = 1'b0, rst = 1'b1, cold_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, analog_power_en, range_double_select, supply_low_irq;
	logic ce = 1'b1; // clock enable, dropped once to check the freeze
	logic slow_8khz_clock, comp_below, prev_slow = 1'b0;
	logic [2:0] threshold_tune, h = 3'h0; // h: model sample history
	logic [15:0] supply_mv = 16'h07d0;
	logic m_en = 1'b0, low_m = 1'b0, mask_m = 1'b0; // model state
	int num_errors = 0, check_count = 0, ticks = 0, i;
	always #5 core_clk = ~core_clk;
	sld_ctrl #(.EOM_CYCLES(16 * TICK + 8)) sld_ctrl_inst (.core_clk, .rst, .cold_rst,
		.ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .slow_8khz_clock, .comp_below,
		.analog_power_en, .range_double_select, .threshold_tune, .supply_low_irq);
	sld_supply_model #(.TICK(TICK)) sld_supply_model_inst (.core_clk, .analog_power_en,
		.range_double_select, .threshold_tune, .supply_mv, .slow_8khz_clock, .comp_below);
	// model takes one sample per tick; frozen with ce, cleared when off
	always @(posedge core_clk) begin
		if (ce)
			prev_slow <= slow_8khz_clock;
		if (!m_en) begin
			ticks <= 0;
			h <= 3'h0;
			low_m <= 1'b0;
		end else if (ce && slow_8khz_clock && !prev_slow) begin
			ticks <= ticks + 1;
			h <= {h[1:0], comp_below};
			if (h[1:0] == {2{comp_below}})
				low_m <= comp_below;
		end
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: read %h, model %h", $time, got, exp);
		end
	endtask
	// bounded wait until sig is seen at a rising edge
	task automatic wait_for(ref logic sig, input logic lvl);
		int n;
		for (n = 0; n < 2 * TICK && sig !== lvl; n++)
			@(posedge core_clk);
		if (sig !== lvl) begin
			num_errors++;
			$display("Error at %0t: wait timed out", $time);
			give_verdict();
		end
	endtask
	// one single ahb transfer; rd gets the read data
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'b1;
		@(posedge core_clk);
		wait_for(hreadyout, 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge core_clk);
		wait_for(hreadyout, 1'b1);
		rd = hrdata;
		chk({hreadyout, hresp}, 32'h2);
	endtask
	task automatic en(input logic e);
		bus(1'b1, `SLD_OFF_STAT, {31'h0, e});
		m_en <= e;
	endtask
	// poll status mid-period after each of n ticks
	task automatic step(input int n);
		repeat (n) begin
			wait_for(slow_8khz_clock, 1'b0);
			wait_for(slow_8khz_clock, 1'b1);
			repeat (4) @(posedge core_clk);
			bus(1'b0, `SLD_OFF_STAT, 32'h0);
			chk({rd[31:3], rd[1:0]}, {29'h0, ticks >= 16, m_en});
			chk(analog_power_en, m_en);
			if (ticks >= 16)
				chk(rd[2], low_m);
			chk(supply_low_irq, ticks >= 16 && low_m && mask_m);
		end
	endtask
	initial begin
		void'($urandom(32'h0f65_02db));
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		cold_rst <= 1'b0;
		@(posedge core_clk);
		// reset values; 0x0c is unmapped and ignores writes
		bus(1'b1, 8'h0c, 32'hffff_ffff);
		for (i = 0; i < 4; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		// every tune code with a random range
		for (i = 0; i < 8; i++) begin
			v = {28'h0, 1'($urandom), 3'(i)};
			bus(1'b1, `SLD_OFF_CTRL, v);
			bus(1'b0, `SLD_OFF_CTRL, 32'h0);
			chk(rd, v);
			chk({range_double_select, threshold_tune}, v[3:0]);
		end
		// system reset clears status and mask only
		bus(1'b1, `SLD_OFF_MASK, 32'h1);
		bus(1'b1, `SLD_OFF_STAT, 32'h1);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (i = 0; i < 3; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0);
			chk(rd, i == 0 ? v : 32'h0);
		end
		cold_rst <= 1'b1;
		@(posedge core_clk);
		cold_rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, `SLD_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk({range_double_select, threshold_tune}, 32'h0);
		// low supply measured tick by tick from enable
		bus(1'b1, `SLD_OFF_CTRL, 32'h4);
		bus(1'b1, `SLD_OFF_MASK, 32'h1);
		mask_m = 1'b1;
		supply_mv = 16'(1100 + $urandom % 100);
		step(1);
		en(1'b1);
		step(18);
		// ce low freezes the detector while the supply rises for three ticks
		ce <= 1'b0;
		supply_mv <= 16'(1500 + $urandom % 100);
		repeat (60) @(posedge core_clk);
		supply_mv <= 16'(1100 + $urandom % 100);
		repeat (10) @(posedge core_clk);
		chk(supply_low_irq, ticks >= 16 && low_m && mask_m);
		ce <= 1'b1;
		step(2);
		// short rise of two samples leaves the flag alone
		supply_mv = 16'(1500 + $urandom % 100);
		step(2);
		supply_mv = 16'(1100 + $urandom % 100);
		step(2);
		// lasting rise clears it, lasting drop sets it again
		supply_mv = 16'(1500 + $urandom % 100);
		step(4);
		supply_mv = 16'(1100 + $urandom % 100);
		step(4);
		bus(1'b1, `SLD_OFF_MASK, 32'h0);
		mask_m = 1'b0;
		step(2);
		// disable clears the flags, enable counts afresh
		en(1'b0);
		step(2);
		en(1'b1);
		step(17);
		give_verdict();
	end
endmodule
